// *** include/sfr_regs.svh ***
// constants of the serial flash read command unit: opcodes, field positions, counts
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

// ********************************************************************
// opcodes (low seven bits; bit 7 selects the clocking category)
// ********************************************************************
`define SFR_OP_VARIANT_BIT 7
`define SFR_OP_CONT 7'h68
`define SFR_OP_PAGE 7'h52
`define SFR_OP_BUF1 7'h54
`define SFR_OP_BUF2 7'h56
`define SFR_OP_STATUS 7'h57

// ********************************************************************
// frame lengths as last bit index of each field
// ********************************************************************
`define SFR_OPC_LAST 6'h07
`define SFR_ADDR_LAST 6'h17
`define SFR_DUMMY_MAIN_LAST 6'h1f
`define SFR_DUMMY_BUF_LAST 6'h07

// ********************************************************************
// address field positions inside the 24-bit address word
// ********************************************************************
`define SFR_PAGE_MSB 20
`define SFR_PAGE_LSB 9
`define SFR_BYTE_MSB 8
`define SFR_BYTE_LSB 0

// ********************************************************************
// array geometry and status layout
// ********************************************************************
`define SFR_LAST_BYTE 9'h107
`define SFR_DENSITY_CODE 3'h4
`define SFR_STATUS_RSVD 3'h0
`define SFR_FIFO_DEPTH 4
`define SFR_FIFO_WIDTH 8

`endif

// *** include/sfr_pkg.sv ***
// types shared by the serial flash read command unit
package sfr_pkg;

  // command decoded from the opcode, one-hot
  typedef enum logic [5:0] {
    SFR_CMD_NONE   = 6'h01,
    SFR_CMD_CONT   = 6'h02,
    SFR_CMD_PAGE   = 6'h04,
    SFR_CMD_BUF1   = 6'h08,
    SFR_CMD_BUF2   = 6'h10,
    SFR_CMD_STATUS = 6'h20
  } sfr_cmd_type;

  // frame phase, one-hot
  typedef enum logic [5:0] {
    SFR_ST_IDLE  = 6'h01,
    SFR_ST_OPC   = 6'h02,
    SFR_ST_ADDR  = 6'h04,
    SFR_ST_DUMMY = 6'h08,
    SFR_ST_DATA  = 6'h10,
    SFR_ST_SKIP  = 6'h20
  } sfr_state_type;

  // which storage a byte fetch targets
  typedef enum logic [1:0] {
    SFR_SRC_MAIN = 2'h0,
    SFR_SRC_BUF1 = 2'h1,
    SFR_SRC_BUF2 = 2'h2
  } sfr_src_type;

  // byte fetch request towards the array and buffer storage
  typedef struct packed {
    sfr_src_type src;
    logic [11:0] page_addr;
    logic [8:0] page_byte_addr;
  } sfr_mem_req_type;

endpackage : sfr_pkg

// *** src/sfr_fifo.sv ***
// small synchronous fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module sfr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // honest full and empty flags straight from the fill count
  // count needs one bit more than the pointers, so full is compared at that width
  assign in_ready = (count_reg != (AW + 1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  // storage write; no reset needed on the data path
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill count; flush drops everything queued
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : sfr_fifo

// *** src/sfr_read_unit.sv ***
// serial command front end: framing, read commands and status read of a paged flash
`timescale 1ns/1ps
`include "sfr_regs.svh"

// What this block does
// - frame starts at chip select fall, opcode first
// - sample opcode and address on serial clock
// - every field travels most significant bit first
// - nine-bit buffer byte, twelve-bit page, nine-bit byte
// - opcode bit seven picks the clocking category
// - continuous read: 24 address, 32 dummy bits
// - ignore three reserved address bits
// - one bit per clock, counter self-advances
// - continuous read crosses pages, wraps array end
// - chip select high ends read, releases output
// - main reads never touch the buffers
// - page read: 24 address, 32 dummy bits
// - page read wraps within the same page
// - buffer read wraps after byte 263
// - status read shifts eight bits, bit seven first
// - upper five bits informative, lower three reserved
// - status repeats with fresh values each byte
// - bit seven is one when ready
// - bit six is the compare mismatch result
module sfr_read_unit (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic device_busy,
  input wire logic compare_mismatch,
  output logic mem_req_valid,
  output sfr_pkg::sfr_mem_req_type mem_req,
  input wire logic mem_rsp_valid,
  input wire logic [7:0] mem_rsp_data
);

  // ******************************************************************
  // pin synchronisers and clock edge detection
  // ******************************************************************
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic sck_meta_reg;
  logic sck_sync_reg;
  logic sck_prev_reg;
  logic si_meta_reg;
  logic si_sync_reg;
  logic rise;
  logic fall;

  // two flops per pin; chip select parks high so no frame starts in reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      sck_meta_reg <= 1'b0;
      sck_sync_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      si_meta_reg <= 1'b0;
      si_sync_reg <= 1'b0;
    end else begin
      cs_meta_reg <= cs_n;
      cs_sync_reg <= cs_meta_reg;
      sck_meta_reg <= sck;
      sck_sync_reg <= sck_meta_reg;
      sck_prev_reg <= sck_sync_reg;
      si_meta_reg <= si;
      si_sync_reg <= si_meta_reg;
    end
  end

  // edges only count inside a frame
  assign rise = !cs_sync_reg && sck_sync_reg && !sck_prev_reg;
  assign fall = !cs_sync_reg && !sck_sync_reg && sck_prev_reg;

  // ******************************************************************
  // frame sequencer
  // ******************************************************************
  sfr_pkg::sfr_state_type state_reg;
  sfr_pkg::sfr_cmd_type cmd_reg;
  sfr_pkg::sfr_cmd_type cmd_next;
  logic spi_variant_reg;
  logic [5:0] bit_cnt_reg;
  logic [23:0] shift_reg;
  logic [7:0] opcode_next;
  logic [23:0] addr_next;
  logic is_main;
  logic [5:0] dummy_last;
  logic addr_done;

  assign opcode_next = {shift_reg[6:0], si_sync_reg};
  assign addr_next = {shift_reg[22:0], si_sync_reg};
  assign is_main = (cmd_reg == sfr_pkg::SFR_CMD_CONT) || (cmd_reg == sfr_pkg::SFR_CMD_PAGE);
  // buffer reads carry only eight trailing dummy bits
  assign dummy_last = is_main ? `SFR_DUMMY_MAIN_LAST : `SFR_DUMMY_BUF_LAST;
  assign addr_done = (state_reg == sfr_pkg::SFR_ST_ADDR) && rise && (bit_cnt_reg == `SFR_ADDR_LAST);

  // variant bit dropped: both forms of a command decode the same
  always_comb begin
    unique case (opcode_next[6:0])
      `SFR_OP_CONT: cmd_next = sfr_pkg::SFR_CMD_CONT;
      `SFR_OP_PAGE: cmd_next = sfr_pkg::SFR_CMD_PAGE;
      `SFR_OP_BUF1: cmd_next = sfr_pkg::SFR_CMD_BUF1;
      `SFR_OP_BUF2: cmd_next = sfr_pkg::SFR_CMD_BUF2;
      `SFR_OP_STATUS: cmd_next = sfr_pkg::SFR_CMD_STATUS;
      default: cmd_next = sfr_pkg::SFR_CMD_NONE;
    endcase
  end

  // msb-first shift of every incoming bit outside the data phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (rise && state_reg != sfr_pkg::SFR_ST_DATA) begin
      shift_reg <= addr_next;
    end
  end

  // phase walk: opcode, address, dummy, data; unknown opcodes are skipped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sfr_pkg::SFR_ST_IDLE;
      cmd_reg <= sfr_pkg::SFR_CMD_NONE;
      spi_variant_reg <= 1'b0;
      bit_cnt_reg <= '0;
    end else if (cs_sync_reg) begin
      state_reg <= sfr_pkg::SFR_ST_IDLE;
      bit_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        sfr_pkg::SFR_ST_IDLE: begin
          state_reg <= sfr_pkg::SFR_ST_OPC;
          cmd_reg <= sfr_pkg::SFR_CMD_NONE;
          bit_cnt_reg <= '0;
        end
        sfr_pkg::SFR_ST_OPC: begin
          if (rise) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == `SFR_OPC_LAST) begin
              bit_cnt_reg <= '0;
              cmd_reg <= cmd_next;
              spi_variant_reg <= opcode_next[`SFR_OP_VARIANT_BIT];
              if (cmd_next == sfr_pkg::SFR_CMD_STATUS) begin
                state_reg <= sfr_pkg::SFR_ST_DATA;
              end else if (cmd_next == sfr_pkg::SFR_CMD_NONE) begin
                state_reg <= sfr_pkg::SFR_ST_SKIP;
              end else begin
                state_reg <= sfr_pkg::SFR_ST_ADDR;
              end
            end
          end
        end
        sfr_pkg::SFR_ST_ADDR: begin
          if (rise) begin
            bit_cnt_reg <= addr_done ? 6'h00 : bit_cnt_reg + 6'h01;
            if (addr_done) begin
              state_reg <= sfr_pkg::SFR_ST_DUMMY;
            end
          end
        end
        sfr_pkg::SFR_ST_DUMMY: begin
          if (rise) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == dummy_last) begin
              bit_cnt_reg <= '0;
              state_reg <= sfr_pkg::SFR_ST_DATA;
            end
          end
        end
        sfr_pkg::SFR_ST_DATA: state_reg <= sfr_pkg::SFR_ST_DATA;
        sfr_pkg::SFR_ST_SKIP: state_reg <= sfr_pkg::SFR_ST_SKIP;
      endcase
    end
  end

  // ******************************************************************
  // byte fetch engine and prefetch fifo
  // ******************************************************************
  sfr_pkg::sfr_mem_req_type fetch_addr_reg;
  sfr_pkg::sfr_mem_req_type mem_req_reg;
  logic fetch_en_reg;
  logic pending_reg;
  logic drop_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic issue;

  // one request in flight at most, so a free slot at issue is a free slot at return
  assign issue = fetch_en_reg && !pending_reg && !drop_reg && fifo_in_ready && !cs_sync_reg;
  assign mem_req = mem_req_reg;

  // address capture and self-advancing counter with per-command wrap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_addr_reg <= '0;
      fetch_en_reg <= 1'b0;
    end else if (cs_sync_reg) begin
      fetch_en_reg <= 1'b0;
    end else if (addr_done) begin
      fetch_en_reg <= 1'b1;
      // reserved top bits are never looked at
      fetch_addr_reg.page_addr <= addr_next[`SFR_PAGE_MSB:`SFR_PAGE_LSB];
      fetch_addr_reg.page_byte_addr <= addr_next[`SFR_BYTE_MSB:`SFR_BYTE_LSB];
      // main reads go straight to the array, leaving both buffers alone
      fetch_addr_reg.src <= is_main ? sfr_pkg::SFR_SRC_MAIN :
        ((cmd_reg == sfr_pkg::SFR_CMD_BUF1) ? sfr_pkg::SFR_SRC_BUF1 : sfr_pkg::SFR_SRC_BUF2);
    end else if (issue) begin
      if (fetch_addr_reg.page_byte_addr == `SFR_LAST_BYTE) begin
        fetch_addr_reg.page_byte_addr <= '0;
        if (cmd_reg == sfr_pkg::SFR_CMD_CONT) begin
          // twelve-bit page wraps from the last page to page zero
          fetch_addr_reg.page_addr <= fetch_addr_reg.page_addr + 12'h001;
        end
      end else begin
        fetch_addr_reg.page_byte_addr <= fetch_addr_reg.page_byte_addr + 9'h001;
      end
    end
  end

  // request pulse, in-flight flag, and discard of a reply that outlives its frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_valid <= 1'b0;
      mem_req_reg <= '0;
      pending_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      mem_req_valid <= issue;
      if (issue) begin
        // counter steps on at this edge, so the pulse carries a snapshot
        mem_req_reg <= fetch_addr_reg;
        pending_reg <= 1'b1;
      end else if (mem_rsp_valid) begin
        pending_reg <= 1'b0;
      end
      if (cs_sync_reg && pending_reg && !mem_rsp_valid) begin
        drop_reg <= 1'b1;
      end else if (mem_rsp_valid) begin
        drop_reg <= 1'b0;
      end
    end
  end

  sfr_fifo #(
    .WIDTH(`SFR_FIFO_WIDTH),
    .DEPTH(`SFR_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .flush(cs_sync_reg),
    .in_valid(mem_rsp_valid && !drop_reg && !cs_sync_reg),
    .in_ready(fifo_in_ready),
    .in_data(mem_rsp_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ******************************************************************
  // serial output shifter
  // ******************************************************************
  logic first_reg;
  logic [7:0] out_byte_reg;
  logic [2:0] out_cnt_reg;
  logic step;
  logic load;
  logic [7:0] status_byte;
  logic [7:0] load_byte;

  // status sampled anew at every byte so each repeat is fresh
  assign status_byte = {!device_busy, compare_mismatch, `SFR_DENSITY_CODE, `SFR_STATUS_RSVD};
  // legacy forms present the first bit at once, spi forms on the next falling edge
  assign step = (state_reg == sfr_pkg::SFR_ST_DATA) && !cs_sync_reg &&
    (spi_variant_reg ? fall : (first_reg || rise));
  assign load = step && (first_reg || out_cnt_reg == 3'h0);
  // an empty fifo here means the storage answered too slowly; the stale entry at the read pointer is sent
  assign fifo_out_ready = load && (cmd_reg != sfr_pkg::SFR_CMD_STATUS);
  assign load_byte = (cmd_reg == sfr_pkg::SFR_CMD_STATUS) ? status_byte : fifo_out_data;
  assign so = out_byte_reg[7];

  // shifter: bit 7 of the byte register is always the bit on the pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_reg <= 1'b1;
      out_byte_reg <= '0;
      out_cnt_reg <= '0;
      so_oe <= 1'b0;
    end else if (cs_sync_reg) begin
      first_reg <= 1'b1;
      so_oe <= 1'b0;
    end else if (load) begin
      first_reg <= 1'b0;
      out_byte_reg <= load_byte;
      out_cnt_reg <= 3'h7;
      so_oe <= 1'b1;
    end else if (step) begin
      out_byte_reg <= {out_byte_reg[6:0], 1'b0};
      out_cnt_reg <= out_cnt_reg - 3'h1;
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  property p_cs_release;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(cs_sync_reg) |=> !so_oe && state_reg == sfr_pkg::SFR_ST_IDLE;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("output not released");

  property p_opcode_len;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == sfr_pkg::SFR_ST_OPC && rise && bit_cnt_reg == 6'h07 && !cs_sync_reg)
      |=> state_reg != sfr_pkg::SFR_ST_OPC && bit_cnt_reg == 6'h00;
  endproperty
  a_opcode_len: assert property (p_opcode_len) else $error("opcode not 8 bits");

  property p_msb_shift;
    @(posedge sys_clk) disable iff (!rst_n)
    (rise && state_reg != sfr_pkg::SFR_ST_DATA)
      |=> shift_reg[0] == $past(si_sync_reg) && shift_reg[23:1] == $past(shift_reg[22:0]);
  endproperty
  a_msb_shift: assert property (p_msb_shift) else $error("input not msb first");

  property p_cont_cross;
    @(posedge sys_clk) disable iff (!rst_n)
    (issue && cmd_reg == sfr_pkg::SFR_CMD_CONT && fetch_addr_reg.page_byte_addr == 9'h107)
      |=> fetch_addr_reg.page_byte_addr == 9'h000
        && fetch_addr_reg.page_addr == $past(fetch_addr_reg.page_addr) + 12'h001;
  endproperty
  a_cont_cross: assert property (p_cont_cross) else $error("page cross wrong");

  property p_page_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    (issue && cmd_reg == sfr_pkg::SFR_CMD_PAGE && fetch_addr_reg.page_byte_addr == 9'h107)
      |=> fetch_addr_reg.page_byte_addr == 9'h000
        && $stable(fetch_addr_reg.page_addr);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page read left page");

  property p_buf_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    (issue && fetch_addr_reg.src != sfr_pkg::SFR_SRC_MAIN
      && fetch_addr_reg.page_byte_addr == 9'h107) |=> fetch_addr_reg.page_byte_addr == 9'h000;
  endproperty
  a_buf_wrap: assert property (p_buf_wrap) else $error("buffer did not wrap");

  property p_main_src;
    @(posedge sys_clk) disable iff (!rst_n)
    (mem_req_valid && (cmd_reg == sfr_pkg::SFR_CMD_CONT || cmd_reg == sfr_pkg::SFR_CMD_PAGE))
      |-> mem_req.src == sfr_pkg::SFR_SRC_MAIN;
  endproperty
  a_main_src: assert property (p_main_src) else $error("main read hit a buffer");

  property p_status_byte;
    @(posedge sys_clk) disable iff (!rst_n)
    (load && cmd_reg == sfr_pkg::SFR_CMD_STATUS) |=> so == !$past(device_busy)
      && out_byte_reg[6] == $past(compare_mismatch) && out_byte_reg[5:3] == 3'h4;
  endproperty
  a_status_byte: assert property (p_status_byte) else $error("status byte wrong");

  property p_dummy_len;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == sfr_pkg::SFR_ST_DUMMY && rise && !cs_sync_reg && is_main
      && bit_cnt_reg == 6'h1e) |=> state_reg == sfr_pkg::SFR_ST_DUMMY && bit_cnt_reg == 6'h1f;
  endproperty
  a_dummy_len: assert property (p_dummy_len) else $error("dummy count short");

endmodule : sfr_read_unit

// *** dv/sfr_mem_model.sv ***
// storage model that answers byte fetches promptly or one cycle late
`timescale 1ns/1ps
module sfr_mem_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic mem_req_valid,
  input wire sfr_pkg::sfr_mem_req_type mem_req,
  input wire logic slow,
  output logic mem_rsp_valid,
  output logic [7:0] mem_rsp_data
);
  logic pend_reg;
  logic [7:0] byte_reg;

  // each source gets its own pattern so a fetch from the wrong store shows
  function automatic logic [7:0] pat(input sfr_pkg::sfr_mem_req_type r);
    logic [7:0] pg;
    pg = 8'h00;
    if (r.src == sfr_pkg::SFR_SRC_MAIN) pg = r.page_addr[7:0] ^ {r.page_addr[11:8], 4'h0};
    return pg ^ r.page_byte_addr[7:0] ^ {r.page_byte_addr[8], 4'h0, r.src, 1'b0};
  endfunction : pat

  // one reply per request; data toggles between replies so stale bytes are not reused
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
      byte_reg <= 8'h00;
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= 8'h00;
    end else begin
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= ~mem_rsp_data;
      if (mem_req_valid && !slow) begin
        mem_rsp_valid <= 1'b1;
        mem_rsp_data <= pat(mem_req);
      end else if (mem_req_valid) begin
        pend_reg <= 1'b1;
        byte_reg <= pat(mem_req);
      end else if (pend_reg) begin
        pend_reg <= 1'b0;
        mem_rsp_valid <= 1'b1;
        mem_rsp_data <= byte_reg;
      end
    end
  end
endmodule : sfr_mem_model

// *** dv/sfr_read_unit_tb_top.sv ***
// self-checking bench: host frames on the serial pins, storage model, fifo fill and drain
`timescale 1ns/1ps
`include "sfr_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module sfr_read_unit_tb_top;
  logic sys_clk, rst_n, cs_n, sck, si, so, so_oe, device_busy, compare_mismatch;
  logic mem_req_valid, mem_rsp_valid, slow;
  sfr_pkg::sfr_mem_req_type mem_req;
  logic [7:0] mem_rsp_data, rx_byte;
  sfr_pkg::sfr_mem_req_type first_req;
  logic [7:0] exp_q[$];
  int error_cnt, n_tests, req_cnt;
  integer seed;
  event rx_ev;
  logic [7:0] op [6] = '{8'h68, 8'he8, 8'h52, 8'hd2, 8'h54, 8'hd6};
  logic [11:0] pg [6] = '{12'hfff, 12'h00a, 12'h007, 12'h12c, 12'h000, 12'h000};
  logic [8:0] by [6] = '{9'h106, 9'h107, 9'h106, 9'h107, 9'h107, 9'h106};

  sfr_read_unit uut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si),
    .so(so), .so_oe(so_oe), .device_busy(device_busy), .compare_mismatch(compare_mismatch),
    .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp_data(mem_rsp_data));
  sfr_mem_model mdl (.sys_clk(sys_clk), .rst_n(rst_n), .mem_req_valid(mem_req_valid),
    .mem_req(mem_req), .slow(slow), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));

  // ******************************************************************
  // host side tasks
  // ******************************************************************
  // half an sck period of 100 ns; inputs move just after a clock edge
  task automatic half();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : half

  // collect one data bit; status frames refresh busy and compare mid-byte
  task automatic grab(input int j, input int nb, input bit stat, inout logic [7:0] b);
    if (j < 0 || j >= 8 * nb) return;
    b = {b[6:0], so};
    // prefetch stops at a full fifo; one refill follows the first byte load
    if (j == 0 && !stat) `CHK("fifo_fill", `SFR_FIFO_DEPTH + 1, req_cnt)
    if (stat && j % 8 == 3 && j < 8 * nb - 8) begin
      device_busy = 1'($random(seed));
      compare_mismatch = 1'($random(seed));
      exp_q.push_back({~device_busy, compare_mismatch, 6'h20});
    end
    if (j % 8 == 7) begin
      `CHK("so_oe_on", 1'b1, so_oe)
      rx_byte = b;
      ->rx_ev;
    end
  endtask : grab

  // one frame: header of h bits, then nb data bytes; sampling point follows the opcode form
  task automatic frame(input logic [7:0] opc, input logic [23:0] adr, input int h,
                       input int nb, input bit stat);
    logic [63:0] hdr;
    logic [7:0] b;
    hdr = {opc, adr, 32'($random(seed))};
    b = 8'h00;
    if (stat) exp_q.push_back({~device_busy, compare_mismatch, 6'h20});
    req_cnt = 0;
    cs_n = 1'b0;
    si = hdr[63];
    half();
    for (int i = 0; i < h + 8 * nb; i++) begin
      sck = 1'b1;
      half();
      if (opc[7]) grab(i - h, nb, stat, b);
      sck = 1'b0;
      si = (i + 1 < h) ? hdr[62 - i] : 1'($random(seed));
      half();
      if (!opc[7]) grab(i - h + 1, nb, stat, b);
    end
    if (nb == 0) `CHK("so_oe_refused", 1'b0, so_oe)
    cs_n = 1'b1;
    half();
    `CHK("so_oe_off", 1'b0, so_oe)
    // a full fifo, plus one refill per loaded byte (nb + 1 loads in all)
    `CHK("fetch_total", (stat || nb == 0) ? 0 : nb + `SFR_FIFO_DEPTH + 1, req_cnt)
  endtask : frame

  // expected bytes of a memory read, stepping the address as the device must
  task automatic mexp(input sfr_pkg::sfr_src_type s, input logic [11:0] p,
                      input logic [8:0] y, input bit same_pg);
    for (int n = 0; n < 4; n++) begin
      exp_q.push_back(mdl.pat('{s, p, y}));
      if (y == `SFR_LAST_BYTE) begin
        y = 9'h000;
        if (!same_pg) p = p + 12'h001;
      end else y = y + 9'h001;
    end
  endtask : mexp

  // print the counts and the verdict, then end the run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // ******************************************************************
  // clock, checker of results, watchdog, main sequence
  // ******************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // oldest expected byte against each byte the host assembled
  initial begin
    logic [7:0] e;
    forever begin
      @(rx_ev);
      e = exp_q.pop_front();
      `CHK("rx_byte", e, rx_byte)
    end
  end

  // fetch requests of the current frame; the first shows the start address
  always @(posedge sys_clk) begin
    if (mem_req_valid) begin
      if (req_cnt == 0) first_req = mem_req;
      req_cnt++;
    end
  end

  // the run needs some 5300 cycles; over seven times that means a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    sfr_pkg::sfr_src_type src;
    seed = 32'hdb0b;
    {rst_n, sck, si, slow, device_busy, compare_mismatch} = 6'h00;
    cs_n = 1'b1;
    error_cnt = 0;
    n_tests = 0;
    repeat (20) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    half();
    compare_mismatch = 1'b1;
    frame(8'h57, 24'h000000, 8, 3, 1'b1);
    device_busy = 1'b1;
    frame(8'hd7, 24'h000000, 8, 2, 1'b1);
    for (int k = 0; k < 6; k++) begin
      src = k < 4 ? sfr_pkg::SFR_SRC_MAIN : (k == 4 ? sfr_pkg::SFR_SRC_BUF1 : sfr_pkg::SFR_SRC_BUF2);
      slow = 1'($random(seed));
      mexp(src, pg[k], by[k], k != 0 && k != 1);
      if (k < 4) frame(op[k], {3'($random(seed)), pg[k], by[k]}, 64, 4, 1'b0);
      else frame(op[k], {15'($random(seed)), by[k]}, 40, 4, 1'b0);
      `CHK("first_src", src, first_req.src)
      `CHK("first_byte", by[k], first_req.page_byte_addr)
      if (k < 4) `CHK("first_page", pg[k], first_req.page_addr)
    end
    frame(8'h11, 24'h000000, 64, 0, 1'b0);
    stop_test();
  end
endmodule : sfr_read_unit_tb_top
